// ==== logic/uhs_uart.sv ====
// 16550-style transceiver with infrared sir option behind axi4-lite
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module uhs_uart #(
  parameter bit SECOND_INST = 1'b1,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serialIn,
  output logic serialOut,
  input wire logic irIn,
  output logic irPulse,
  input wire logic ctsN,
  output logic rtsN,
  output logic baudOutN,
  output logic txDmaReq,
  output logic rxDmaReq
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uhs_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uhs_rx_t;
  typedef struct packed {
    logic [1:0] serSync, irSync, ctsSync;
    logic awTaken, wTaken, bvalid, rvalid;
    logic [7:0] awAddr;
    logic [7:0] wByte;
    logic wLane;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic [7:0] ien, line, modem, divLo, divHi, lpLo, lpHi;
    logic [3:0] frac, fracAcc, settle;
    logic fifoEn;
    logic [1:0] txThr, rxTrig;
    logic [15:0] divCnt;
    logic tick, baudOutN, serialOut, irPulse;
    uhs_tx_t txState;
    logic [5:0] txTick;
    logic [2:0] txBit;
    logic [7:0] txShift;
    logic txPar;
    logic [DEPTH-1:0][7:0] txMem;
    logic [3:0] txRd, txWr;
    logic [4:0] txCnt;
    uhs_rx_t rxState;
    logic [4:0] rxTick, irStretch;
    logic [15:0] irLow;
    logic [2:0] rxBit;
    logic [7:0] rxShift;
    logic rxPar, prevIn;
    logic [DEPTH-1:0][7:0] rxMem;
    logic [3:0] rxRd, rxWr;
    logic [4:0] rxCnt;
    logic ovr, perr, ferr, brk, threPend, threPrev, tmo;
    logic [11:0] tmoCnt;
  } uhs_state_t;

  uhs_state_t s, n;

  // 4-bit wrap of a fifo pointer against the configured depth
  function automatic logic [3:0] bump(input logic [3:0] p);
    bump = (p == 4'(DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  logic sir, parEn, ptime, rxIn, lineInt, rdaInt, tmoInt, threInt, threCond, flow;
  logic [2:0] lastBit;
  logic [5:0] stopTicks;
  logic [4:0] cap, trigLvl, thrLvl;
  logic [15:0] effDiv, lpDiv;
  logic [11:0] tmoLimit;
  logic [3:0] iid;

  // sir overrides the character format
  assign sir = s.modem[uhs_pkg::MODEM_SIR];
  assign lastBit = sir ? 3'h7 : {1'b1, s.line[1:0]}; // length code plus four is the last bit index
  assign parEn = !sir && s.line[3];
  // 1.5 stop bits only with 5 data bits, 2 otherwise
  assign stopTicks = (sir || !s.line[2]) ? uhs_pkg::TICKS_BIT :
                     (s.line[1:0] == 2'h0) ? 6'h18 : 6'h20;
  // first build is held to one-character holding registers
  assign cap = (SECOND_INST && s.fifoEn) ? 5'(DEPTH) : 5'h01;
  assign flow = SECOND_INST;
  assign effDiv = ({s.divHi, s.divLo} == 16'h0) ? 16'h1 : {s.divHi, s.divLo};
  assign lpDiv = ({s.lpHi, s.lpLo} == 16'h0) ? 16'h1 : {s.lpHi, s.lpLo};
  assign trigLvl = (s.rxTrig == 2'h0) ? 5'h01 : (s.rxTrig == 2'h1) ? 5'h04 :
                   (s.rxTrig == 2'h2) ? 5'h08 : 5'h0E;
  assign thrLvl = (s.txThr == 2'h0) ? 5'h00 : (s.txThr == 2'h1) ? 5'h02 :
                  (s.txThr == 2'h2) ? 5'h04 : 5'h08;
  // four frames of start, data, parity and stop, in baud ticks
  assign tmoLimit = 12'(uhs_pkg::TMO_CHARS) * (12'(lastBit) + 12'h3 + 12'(parEn) + 12'(s.line[2])) * 12'h10;
  // infrared input is already inverted by the receiver, a low is a zero
  assign rxIn = sir ? (s.irStretch == 5'h0) : s.serSync[1];
  assign ptime = SECOND_INST && s.fifoEn && s.ien[7];
  assign threCond = ptime ? (s.txCnt <= thrLvl) : (s.txCnt == 5'h0);
  assign lineInt = s.ien[2] && (s.ovr || s.perr || s.ferr || s.brk);
  assign rdaInt = s.ien[0] && (s.rxCnt >= (s.fifoEn ? trigLvl : 5'h01));
  assign tmoInt = s.ien[0] && s.tmo;
  assign threInt = s.ien[1] && s.threPend;
  // fixed priority of interrupt sources
  assign iid = lineInt ? uhs_pkg::IID_LINE : rdaInt ? uhs_pkg::IID_RDA :
               tmoInt ? uhs_pkg::IID_TMO : threInt ? uhs_pkg::IID_TX_HOLDING_EMPTY : uhs_pkg::IID_NONE;

  // register read mux, also used to flag unmapped offsets
  function automatic logic [8:0] rd_mux(input logic [7:0] a, input uhs_state_t c, input logic [3:0] id,
                                        input logic lsr5);
    unique case (a)
      uhs_pkg::OFS_DATA: rd_mux = {1'b1, c.rxMem[c.rxRd]};
      uhs_pkg::OFS_IEN: rd_mux = {1'b1, c.ien};
      uhs_pkg::OFS_IID: rd_mux = {1'b1, {2{c.fifoEn}}, 2'h0, id};
      uhs_pkg::OFS_LINE: rd_mux = {1'b1, c.line};
      uhs_pkg::OFS_MODEM: rd_mux = {1'b1, c.modem};
      uhs_pkg::OFS_LSTAT: rd_mux = {1'b1, 1'b0, c.txCnt == 5'h0 && c.txState == TX_IDLE, lsr5,
                                    c.brk, c.ferr, c.perr, c.ovr, c.rxCnt != 5'h0};
      uhs_pkg::OFS_DIVLO: rd_mux = {1'b1, c.divLo};
      uhs_pkg::OFS_DIVHI: rd_mux = {1'b1, c.divHi};
      uhs_pkg::OFS_FRAC: rd_mux = {1'b1, 4'h0, c.frac};
      uhs_pkg::OFS_LPLO: rd_mux = {1'b1, c.lpLo};
      uhs_pkg::OFS_LPHI: rd_mux = {1'b1, c.lpHi};
      uhs_pkg::OFS_SHADOW: rd_mux = {1'b1, 8'h00};
      default: rd_mux = 9'h000;
    endcase
  endfunction

  logic [8:0] rdv;
  logic lsr5;
  assign lsr5 = ptime ? (s.txCnt == cap) : (s.txCnt == 5'h0);
  assign rdv = rd_mux(araddr, s, iid, lsr5);

  // all next-state logic; bus writes first, engines after, then bus reads and interrupt sets
  always_comb begin
    logic wr, swRst;
    logic [7:0] d;
    logic [8:0] wmux;
    n = s;
    wmux = rd_mux(s.awAddr, s, iid, lsr5);
    wr = s.awTaken && s.wTaken;
    swRst = 1'b0;
    d = s.wByte;
    // two-flop synchronisers on pins
    n.serSync = {s.serSync[0], serialIn};
    n.irSync = {s.irSync[0], irIn};
    n.ctsSync = {s.ctsSync[0], ctsN};
    if (awvalid && awready) begin
      n.awTaken = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      n.wTaken = 1'b1;
      n.wByte = wdata[7:0];
      n.wLane = wstrb[0];
    end
    if (s.bvalid && bready) n.bvalid = 1'b0;
    if (s.rvalid && rready) n.rvalid = 1'b0;
    if (s.settle != 4'h0) n.settle = s.settle - 4'h1;
    if (wr) begin
      n.awTaken = 1'b0;
      n.wTaken = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wmux[8] ? 2'h0 : 2'h2; // unmapped offsets answer slverr
      if (s.wLane) begin
        unique case (s.awAddr)
          uhs_pkg::OFS_DATA: if (s.txCnt < cap) begin
            n.txMem[s.txWr] = d;
            n.txWr = bump(s.txWr);
            n.txCnt = n.txCnt + 5'h1;
            n.threPend = 1'b0;
          end
          uhs_pkg::OFS_IEN: n.ien = d;
          uhs_pkg::OFS_IID: begin
            n.fifoEn = d[0];
            n.rxTrig = d[7:6];
            n.txThr = d[5:4];
            if (d[1] || d[0] != s.fifoEn) {n.rxRd, n.rxWr, n.rxCnt} = '0;
            if (d[2] || d[0] != s.fifoEn) {n.txRd, n.txWr, n.txCnt} = '0;
          end
          uhs_pkg::OFS_LINE: begin n.line = d; n.settle = uhs_pkg::SETTLE_CYC; end
          uhs_pkg::OFS_MODEM: begin n.modem = d; n.settle = uhs_pkg::SETTLE_CYC; end
          uhs_pkg::OFS_DIVLO: begin n.divLo = d; n.settle = uhs_pkg::SETTLE_CYC; end
          uhs_pkg::OFS_DIVHI: begin n.divHi = d; n.settle = uhs_pkg::SETTLE_CYC; end
          uhs_pkg::OFS_FRAC: begin n.frac = d[3:0]; n.settle = uhs_pkg::SETTLE_CYC; end
          uhs_pkg::OFS_LPLO: n.lpLo = d;
          uhs_pkg::OFS_LPHI: n.lpHi = d;
          uhs_pkg::OFS_SHADOW: begin // single-write controls, no read-modify-write
            swRst = d[0];
            if (d[1]) {n.rxRd, n.rxWr, n.rxCnt} = '0;
            if (d[2]) {n.txRd, n.txWr, n.txCnt} = '0;
          end
          default: ;
        endcase
      end
    end
    // baud generator: divisor d+f/16 by stretching some periods one clock
    n.tick = 1'b0;
    if (s.divCnt <= 16'h1) begin
      n.tick = 1'b1;
      {d[0], n.fracAcc} = {1'b0, s.fracAcc} + {1'b0, s.frac};
      n.divCnt = d[0] ? effDiv + 16'h1 : effDiv;
    end else begin
      n.divCnt = s.divCnt - 16'h1;
    end
    n.baudOutN = !n.tick;
    // transmitter
    if (s.tick && s.txState != TX_IDLE) n.txTick = s.txTick + 6'h1;
    unique case (s.txState)
      TX_IDLE: if (s.tick && s.settle == 4'h0 && s.txCnt != 5'h0 && !(flow && s.modem[5] && s.ctsSync[1])) begin
        n.txShift = s.txMem[s.txRd] & (8'hFF >> (3'h7 - lastBit));
        n.txPar = ^n.txShift ^ !s.line[4];
        n.txRd = bump(s.txRd);
        n.txCnt = n.txCnt - 5'h1;
        n.txState = TX_START;
        n.txTick = 6'h0;
      end
      TX_START: if (s.tick && s.txTick == uhs_pkg::TICKS_BIT - 6'h1) begin
        n.txState = TX_DATA;
        n.txTick = 6'h0;
        n.txBit = 3'h0;
      end
      TX_DATA: if (s.tick && s.txTick == uhs_pkg::TICKS_BIT - 6'h1) begin // lsb first
        n.txTick = 6'h0;
        n.txShift = s.txShift >> 1;
        n.txBit = s.txBit + 3'h1;
        if (s.txBit == lastBit) n.txState = parEn ? TX_PAR : TX_STOP;
      end
      TX_PAR: if (s.tick && s.txTick == uhs_pkg::TICKS_BIT - 6'h1) begin
        n.txTick = 6'h0;
        n.txState = TX_STOP;
      end
      TX_STOP: if (s.tick && s.txTick == stopTicks - 6'h1) begin // half stop bit only here
        n.txState = TX_IDLE;
        n.txTick = 6'h0;
      end
    endcase
    // line level; break forces a low on the normal output
    d[1] = (s.txState == TX_START) ? 1'b0 : (s.txState == TX_DATA) ? s.txShift[0] :
           (s.txState == TX_PAR) ? s.txPar : 1'b1;
    n.serialOut = sir ? 1'b1 : (d[1] && !s.line[uhs_pkg::LINE_BREAK]);
    n.irPulse = sir && !d[1] && s.txTick < uhs_pkg::TICKS_SIR;
    // infrared pulse stretch so the mid-bit sample still sees the pulse
    if (!s.irSync[1]) n.irLow = s.irLow + 16'h1;
    else n.irLow = 16'h0;
    if (!s.irSync[1] && (!s.modem[uhs_pkg::MODEM_LP] || s.irLow + 16'h1 >= lpDiv)) begin
      n.irStretch = uhs_pkg::TICKS_STRETCH;
    end else if (s.tick && s.irStretch != 5'h0) begin
      n.irStretch = s.irStretch - 5'h1;
    end
    // status read clears before the receiver, so an error in the same cycle survives
    if (arvalid && arready && araddr == uhs_pkg::OFS_LSTAT) {n.ovr, n.perr, n.ferr, n.brk} = '0;
    // receiver
    n.prevIn = rxIn;
    if (s.tick && s.rxState != RX_IDLE) n.rxTick = s.rxTick + 5'h1;
    unique case (s.rxState)
      RX_IDLE: if (s.settle == 4'h0 && s.prevIn && !rxIn) begin
        n.rxState = RX_START;
        n.rxTick = 5'h0;
      end
      RX_START: if (s.tick && s.rxTick == uhs_pkg::TICKS_MID - 5'h1) begin // mid sample
        n.rxTick = 5'h0;
        n.rxBit = 3'h0;
        n.rxShift = 8'h00;
        n.rxState = rxIn ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (s.tick && s.rxTick == 5'(uhs_pkg::TICKS_BIT) - 5'h1) begin
        n.rxTick = 5'h0;
        n.rxShift[s.rxBit] = rxIn;
        n.rxBit = s.rxBit + 3'h1;
        if (s.rxBit == lastBit) n.rxState = parEn ? RX_PAR : RX_STOP;
      end
      RX_PAR: if (s.tick && s.rxTick == 5'(uhs_pkg::TICKS_BIT) - 5'h1) begin
        n.rxTick = 5'h0;
        n.rxPar = rxIn;
        n.perr = n.perr || (rxIn != (^s.rxShift ^ !s.line[4]));
        n.rxState = RX_STOP;
      end
      RX_STOP: if (s.tick && s.rxTick == 5'(uhs_pkg::TICKS_BIT) - 5'h1) begin
        n.rxState = RX_IDLE;
        n.ferr = n.ferr || !rxIn;
        n.brk = n.brk || (!rxIn && s.rxShift == 8'h00 && !(parEn && s.rxPar));
        if (s.rxCnt < cap) begin
          n.rxMem[s.rxWr] = s.rxShift;
          n.rxWr = bump(s.rxWr);
          n.rxCnt = n.rxCnt + 5'h1;
        end else begin
          n.ovr = 1'b1;
        end
        n.tmoCnt = 12'h0;
      end
    endcase
    // bus reads; hardware sets below win over these clears
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rdata = {24'h0, rdv[7:0]};
      n.rresp = rdv[8] ? 2'h0 : 2'h2;
      if (araddr == uhs_pkg::OFS_DATA && s.rxCnt != 5'h0) begin
        n.rxRd = bump(s.rxRd);
        n.rxCnt = n.rxCnt - 5'h1;
        n.tmoCnt = 12'h0;
        n.tmo = 1'b0;
      end
      if (araddr == uhs_pkg::OFS_IID && iid == uhs_pkg::IID_TX_HOLDING_EMPTY) n.threPend = 1'b0;
    end
    // empty or threshold event, set wins over the write and read clears; software reset still clears it
    n.threPrev = threCond;
    if (threCond && !s.threPrev) n.threPend = 1'b1;
    // character timeout
    if (s.rxCnt == 5'h0) n.tmoCnt = 12'h0;
    else if (s.tick && s.tmoCnt < tmoLimit) n.tmoCnt = n.tmoCnt + 12'h1;
    if (s.rxCnt != 5'h0 && s.tmoCnt == tmoLimit) n.tmo = 1'b1;
    if (s.rxCnt == 5'h0) n.tmo = 1'b0;
    if (swRst) begin // software reset keeps the bus handshake alive
      {n.txCnt, n.txRd, n.txWr, n.rxCnt, n.rxRd, n.rxWr} = '0;
      n.txState = TX_IDLE;
      n.rxState = RX_IDLE;
      {n.ovr, n.perr, n.ferr, n.brk, n.threPend, n.tmo, n.ien, n.modem, n.fifoEn} = '0;
      n.line = uhs_pkg::RST_LINE;
      n.settle = uhs_pkg::SETTLE_CYC;
    end
  end

  // one state register for the whole block
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.serSync <= 2'h3;
      s.irSync <= 2'h3;
      s.ctsSync <= 2'h3;
      s.divLo <= uhs_pkg::RST_DIVLO;
      s.line <= uhs_pkg::RST_LINE;
      s.settle <= uhs_pkg::SETTLE_CYC;
      s.serialOut <= 1'b1;
      s.baudOutN <= 1'b1;
      s.prevIn <= 1'b1;
      s.threPrev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // handshakes combinational, data from flops
  assign awready = !s.awTaken && !s.bvalid;
  assign wready = !s.wTaken && !s.bvalid;
  assign arready = !s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign serialOut = s.serialOut;
  assign irPulse = s.irPulse;
  assign baudOutN = s.baudOutN;
  // dma asks while there is room to fill or data to drain
  assign txDmaReq = s.txCnt < cap;
  assign rxDmaReq = s.rxCnt != 5'h0;
  // rts only on the second build, dropped when the fifo nears full
  assign rtsN = !(flow && s.modem[1] && (!s.modem[5] || s.rxCnt + 5'h2 < cap));

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_start_low: assert property (s.txState == TX_START && !sir && !s.line[6] |=> !serialOut)
    else $error("start bit not low");
  a_sir_pulse_len: assert property (sir && s.txState == TX_START && s.txTick >= 6'h3 |=> !irPulse)
    else $error("sir pulse too long");
  a_sir_pulse_on: assert property (sir && s.txState == TX_START && s.txTick < 6'h3 |=> irPulse)
    else $error("sir pulse missing");
  a_bit_ticks: assert property (s.txState == TX_DATA && !(s.tick && s.txTick == 6'hF) |=> s.txState == TX_DATA)
    else $error("data bit ended early");
  a_rx_abort: assert property (s.rxState == RX_START && s.tick && s.rxTick == 5'h7 && rxIn |=> s.rxState == RX_IDLE)
    else $error("false start kept");
  a_settle_gate: assert property (s.settle != 4'h0 && s.txState == TX_IDLE |=> s.txState == TX_IDLE)
    else $error("sent during settle");
  a_iir_prio: assert property (lineInt && arvalid && arready && araddr == uhs_pkg::OFS_IID
    |=> rdata[3:0] == uhs_pkg::IID_LINE)
    else $error("line status not first");
  a_sir_quiet: assert property (sir |=> serialOut)
    else $error("serial pin active in sir");
  a_break_out: assert property (s.line[6] && !sir |=> !serialOut)
    else $error("break not driven");
  a_baud_gap: assert property (s.tick && effDiv > 16'h1 && $stable(effDiv) |=> !s.tick)
    else $error("ticks too close");

  c_tx_done: cover property (s.txState == TX_STOP ##1 s.txState == TX_IDLE);
  c_rx_push: cover property (s.rxCnt == 5'h0 ##1 s.rxCnt == 5'h1);
  c_sir_pulse: cover property (sir && irPulse);
  c_timeout: cover property (s.tmo);
endmodule // uhs_uart

// ==== logic/uhs_pkg.sv ====
// constants shared by the serial transceiver
// Function
// - two builds; only the second has 16-byte fifos and rts/cts
// - 5 to 8 data bits, odd/even parity option, 1, 1.5 or 2 stops
// - start bit, data lsb first, parity, then stop bits
// - every bit lasts 16 baud ticks, except the half stop bit
// - receiver samples start mid point, then every 16 ticks
// - baud equals serial clock over sixteen times a programmable divisor
// - divisor settings reproduce the listed baud rates
// - optional active-low baud clock reference output
// - sir mode is limited to 115.2 kbaud
// - sir mode forces 8 data bits, no parity, one stop
// - modem control bit 6 moves data to the infrared pins
// - sir zero is one pulse of 3/16 bit, one is no pulse
// - infrared input arrives inverted, read with normal polarity
// - low-power sir reception timed by low-power divisor
// - low-power divisor 1, 2 or 3 for slow serial clocks
// - one clock; only the serial, infrared and cts pins pass two-flop synchronisers
// - break generation on output and detection on input
// - prioritised interrupt id and programmable empty threshold
// - shadow control bits including a software reset
// - dma requests for transmit and receive characters
// - bus writes are sent, received characters are read back
// - id codes 0110, 0100, 1100, 0010, none 0001
// - timeout after 4 character times without fifo activity
// - no traffic until eight clocks after configuration
package uhs_pkg;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_IEN = 8'h04;
  localparam logic [7:0] OFS_IID = 8'h08;
  localparam logic [7:0] OFS_LINE = 8'h0C;
  localparam logic [7:0] OFS_MODEM = 8'h10;
  localparam logic [7:0] OFS_LSTAT = 8'h14;
  localparam logic [7:0] OFS_DIVLO = 8'h18;
  localparam logic [7:0] OFS_DIVHI = 8'h1C;
  localparam logic [7:0] OFS_FRAC = 8'h20;
  localparam logic [7:0] OFS_LPLO = 8'h24;
  localparam logic [7:0] OFS_LPHI = 8'h28;
  localparam logic [7:0] OFS_SHADOW = 8'h2C;
  localparam int MODEM_SIR = 6;
  localparam int MODEM_LP = 7;
  localparam int LINE_BREAK = 6;
  localparam logic [7:0] RST_DIVLO = 8'h01;
  localparam logic [7:0] RST_LINE = 8'h03;
  localparam logic [3:0] IID_LINE = 4'h6;
  localparam logic [3:0] IID_RDA = 4'h4;
  localparam logic [3:0] IID_TMO = 4'hC;
  localparam logic [3:0] IID_TX_HOLDING_EMPTY = 4'h2;
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [4:0] TICKS_MID = 5'h08;
  localparam logic [5:0] TICKS_SIR = 6'h03;
  localparam logic [4:0] TICKS_STRETCH = 5'h0C;
  localparam logic [3:0] SETTLE_CYC = 4'h8;
  localparam logic [3:0] TMO_CHARS = 4'h4;
endpackage

// ==== sim/uhs_serial_peer.sv ====
// behavioural serial peripheral on the normal serial pins
`timescale 1ns/1ns
module uhs_serial_peer #(
  parameter int BIT_CLKS = 32
) (
  input wire logic ref_clk,
  input wire logic lineIn,
  output logic lineOut
);
  logic [10:0] frame;
  int frameCount;

  initial begin
    lineOut = 1'h1;
    frame = '0;
    frameCount = 0;
  end

  // sample eleven slots at mid bit; idle line after the stop reads high
  always begin
    @(negedge lineIn);
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      frame[i] = lineIn;
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    frameCount++;
  end

  // start, data lsb first, one stop; line stays high afterwards
  task automatic sendChar(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      lineOut <= f[i];
      repeat (BIT_CLKS - 1) @(posedge ref_clk);
    end
  endtask

  // low blip of n clocks; a short one must not start a character, a long one is a break
  task automatic glitch(input int n);
    @(posedge ref_clk);
    lineOut <= 1'h0;
    repeat (n) @(posedge ref_clk);
    lineOut <= 1'h1;
  endtask
endmodule // uhs_serial_peer

// ==== sim/tb_uart_16550_with_irda_sir.sv ====
// self-checking bench for the serial transceiver
`timescale 1ns/1ns
module tb_uart_16550_with_irda_sir;
  localparam int BITC = 32;
  localparam int SIRDIV = 55;
  logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, irIn, ctsN;
  logic awready, wready, bvalid, arready, rvalid, serialIn, serialOut;
  logic irPulse, rtsN, baudOutN, txDmaReq, rxDmaReq;
  logic [7:0] awaddr, araddr, d;
  logic [9:0] irFrame;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, br, rr;
  int mismatches, check_count, seed, baudLow, irHigh, soLow, n0;
  logic [7:0] lcTab [6] = '{8'h03, 8'h00, 8'h0B, 8'h1A, 8'h07, 8'h19};
  int bDiv [3] = '{3, 2, 2};
  int bFrac [3] = '{0, 8, 0};
  int bExp [3] = '{160, 192, 240};

  uhs_uart #(.SECOND_INST(1'h1), .DEPTH(16)) uhs_uart_inst (.ref_clk(ref_clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .serialIn(serialIn), .serialOut(serialOut),
    .irIn(irIn), .irPulse(irPulse), .ctsN(ctsN), .rtsN(rtsN), .baudOutN(baudOutN), .txDmaReq(txDmaReq),
    .rxDmaReq(rxDmaReq));
  uhs_serial_peer #(.BIT_CLKS(BITC)) uhs_serial_peer_inst (.ref_clk(ref_clk), .lineIn(serialOut),
    .lineOut(serialIn));

  // bus and serial side share this clock, so the four-to-one limit holds
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // tick and pulse counters for timing checks
  always @(posedge ref_clk) begin
    baudLow += (baudOutN === 1'h0);
    irHigh += (irPulse === 1'h1);
    soLow += (serialOut === 1'h0);
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write; each channel dropped at the edge where it was taken
  task wr(input logic [7:0] a, input logic [7:0] v);
    logic ha, hw, hb;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hb = 1'h0;
    for (int i = 0; i < 40 && !hb; i++) begin
      @(negedge ref_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      br = bresp;
      @(posedge ref_clk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
      if (hb) bready <= 1'h0;
    end
    if (!hb) begin
      mismatches++;
      $display("Error at %0t: write not answered", $time);
    end
  endtask

  task rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    hr = 1'h0;
    for (int i = 0; i < 40 && !hr; i++) begin
      @(negedge ref_clk);
      ha = arvalid && arready;
      hr = rvalid;
      rdv = rdata;
      rr = rresp;
      @(posedge ref_clk);
      if (ha) arvalid <= 1'h0;
      if (hr) rready <= 1'h0;
    end
    if (!hr) begin
      mismatches++;
      $display("Error at %0t: read not answered", $time);
    end
  endtask

  // serial side needs eight clocks to see new settings before traffic
  task cfg(input logic [7:0] a, input logic [7:0] v);
    wr(a, v);
    repeat (10) @(posedge ref_clk);
  endtask

  function automatic logic [10:0] expFrame(input logic [7:0] v, input logic [7:0] lc);
    logic [10:0] f;
    logic [7:0] m;
    int nb;
    nb = lc[1:0] + 5;
    m = 8'hFF >> (8 - nb);
    f = 11'h7FE;
    for (int i = 0; i < nb; i++) f[i + 1] = v[i];
    if (lc[3]) f[nb + 1] = lc[4] ? ^(v & m) : ~^(v & m);
    return f;
  endfunction

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up;
  end

  initial begin
    {rst, seed, mismatches, check_count} = {1'h1, 32'hE382, 64'h0};
    {awvalid, wvalid, bready, arvalid, rready, irIn, ctsN} = 7'h02;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    chk({serialOut, irPulse, baudOutN, txDmaReq, rxDmaReq, rtsN, bvalid, rvalid}, 8'hB4);
    rd(uhs_pkg::OFS_LINE);
    chk(rdv, {24'h0, uhs_pkg::RST_LINE});
    rd(uhs_pkg::OFS_DIVLO);
    chk(rdv, {24'h0, uhs_pkg::RST_DIVLO});
    rd(8'h40);
    chk(rr, 2'h2);
    wr(8'h44, 8'h5A);
    chk(br, 2'h2);
    $display("register test done");
    for (int k = 0; k < 3; k++) begin
      cfg(uhs_pkg::OFS_DIVLO, 8'(bDiv[k]));
      cfg(uhs_pkg::OFS_FRAC, 8'(bFrac[k]));
      @(negedge ref_clk);
      baudLow = 0;
      repeat (480) @(negedge ref_clk);
      chk(32'(baudLow >= bExp[k] - 1 && baudLow <= bExp[k] + 1), 32'h1);
    end
    $display("baud test done");
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed));
      cfg(uhs_pkg::OFS_LINE, lcTab[k]);
      n0 = uhs_serial_peer_inst.frameCount;
      wr(uhs_pkg::OFS_DATA, d);
      for (int i = 0; i < 1000 && uhs_serial_peer_inst.frameCount == n0; i++) @(posedge ref_clk);
      chk(uhs_serial_peer_inst.frame, expFrame(d, lcTab[k]));
    end
    $display("transmit test done");
    cfg(uhs_pkg::OFS_LINE, 8'h43);
    chk(serialOut, 1'h0);
    cfg(uhs_pkg::OFS_LINE, 8'h03);
    repeat (12 * BITC) @(posedge ref_clk);
    $display("break test done");
    for (int k = 0; k < 4; k++) begin
      d = (k < 2) ? {8{k[0]}} : 8'($random(seed));
      uhs_serial_peer_inst.sendChar(d);
      for (int i = 0; i < 100 && rxDmaReq !== 1'h1; i++) @(posedge ref_clk);
      rd(uhs_pkg::OFS_DATA);
      chk(rdv, {24'h0, d});
    end
    uhs_serial_peer_inst.glitch(4);
    repeat (3 * BITC) @(posedge ref_clk);
    chk(rxDmaReq, 1'h0);
    cfg(uhs_pkg::OFS_IEN, 8'h05);
    uhs_serial_peer_inst.glitch(12 * BITC); // a long low is a break
    repeat (2 * BITC) @(posedge ref_clk);
    rd(uhs_pkg::OFS_IID);
    chk(rdv[3:0], uhs_pkg::IID_LINE);
    rd(uhs_pkg::OFS_LSTAT);
    chk(rdv[4:3], 2'h3);
    rd(uhs_pkg::OFS_IID);
    chk(rdv[3:0], uhs_pkg::IID_RDA);
    rd(uhs_pkg::OFS_DATA);
    chk(rdv, 32'h0);
    $display("receive test done");
    cfg(uhs_pkg::OFS_DIVLO, 8'(SIRDIV));
    cfg(uhs_pkg::OFS_LINE, 8'h18);
    cfg(uhs_pkg::OFS_MODEM, 8'h40);
    d = 8'($random(seed));
    @(negedge ref_clk);
    irHigh = 0;
    soLow = 0;
    wr(uhs_pkg::OFS_DATA, d);
    repeat (12 * 16 * SIRDIV) @(posedge ref_clk);
    chk(irHigh, 3 * SIRDIV * (9 - $countones(d)));
    chk(soLow, 0);
    // receive only once the transmit is over, half duplex
    d = 8'($random(seed));
    irFrame = {1'h1, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      irIn <= irFrame[i]; // a zero arrives as a low pulse
      repeat (3 * SIRDIV) @(posedge ref_clk);
      irIn <= 1'h1;
      repeat (13 * SIRDIV) @(posedge ref_clk);
    end
    rd(uhs_pkg::OFS_DATA);
    chk(rdv, {24'h0, d});
    $display("infrared test done");
    wrap_up;
  end
endmodule // tb_uart_16550_with_irda_sir
